// ===== design/eia_pkg.sv
package eia_pkg;
    // Group layout and block-select ports in the controller's own register space
    localparam int EIA_NUM_GROUPS = 19;
    localparam int EIA_GROUP_W = 32;
    localparam int EIA_ADDR_W = 10;
    localparam int EIA_FIRST_IRQ = 8;
    localparam logic [9:0] EIA_GROUP_STRIDE = 10'h014;
    localparam logic [9:0] EIA_OFS_SRC = 10'h000;
    localparam logic [9:0] EIA_OFS_EN_SET = 10'h004;
    localparam logic [9:0] EIA_OFS_RESULT = 10'h008;
    localparam logic [9:0] EIA_OFS_EN_CLR = 10'h00c;
    localparam logic [9:0] EIA_OFS_BLK_SET = 10'h200;
    localparam logic [9:0] EIA_OFS_BLK_CLR = 10'h204;
    // Reset values
    localparam logic [31:0] EIA_SRC_RST = 32'h0000_0000;
    localparam logic [31:0] EIA_EN_RST = 32'h0000_0000;
    localparam logic [31:0] EIA_RD_RST = 32'h0000_0000;

    // One register access from the embedded controller
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [31:0] wdata;
    } eia_req_s;

    // Processor exceptions, carried past the aggregator untouched
    typedef struct packed {
        logic reset;
        logic mem_err;
        logic instr_err;
    } eia_exc_s;
endpackage

// ===== design/eia_aggregator.sv
`timescale 1ns/1ns
// What this block does
// - Exceptions pass straight through, never masked.
// - Wake sources detected without any running clock.
// - Registers reachable only through controller port.
// - Each group ORs unmasked bits to IRQ.
// - Group has source, enable-set, enable-clear, result.
// - Source and enable bits are latched storage.
// - Both enable ports read one enable value.
// - Set port sets, clear port clears selected bits.
// - Result equals source AND enable per bit.
// - Group interrupt is OR of result, block-gated.
// - Direct-vector enable routes result bits individually.
// - Everything resets to defaults on standby reset.
// - Needs clk except for the wake path; no power-mode control.
// - Wake event: OR of enabled wake sources.
// - Block-select set/clear ports after all groups.
module eia_aggregator
    import eia_pkg::*;
#(
    parameter int NUM_GROUPS = EIA_NUM_GROUPS
) (
    // Clock and standby-rail reset
    input wire logic clk,
    input wire logic nrst,
    // Controller register port
    input eia_req_s req,
    output logic [31:0] rdata,
    // Interrupt sources and wake capability per bit
    input wire logic [NUM_GROUPS-1:0][31:0] irq_src,
    input wire logic [NUM_GROUPS-1:0][31:0] wake_capable,
    input wire logic direct_vector_enable,
    // Towards the vectored_irq_controller
    output logic [NUM_GROUPS-1:0] group_irq,
    output logic [NUM_GROUPS-1:0][31:0] direct_irq,
    output logic wake_event,
    // Exception bypass
    input eia_exc_s exc_in,
    output eia_exc_s exc_out
);
    localparam logic [9:0] GROUP_END = 10'(NUM_GROUPS) * EIA_GROUP_STRIDE;

    logic [NUM_GROUPS-1:0][31:0] src_reg, src_next;
    logic [NUM_GROUPS-1:0][31:0] en_reg, en_next;
    logic [NUM_GROUPS-1:0][31:0] result;
    logic [NUM_GROUPS-1:0][31:0] wake_hit;
    logic [NUM_GROUPS-1:0] blk_reg, blk_next;
    logic [NUM_GROUPS-1:0] group_irq_reg, group_irq_next;
    logic [NUM_GROUPS-1:0][31:0] direct_irq_reg, direct_irq_next;
    logic [31:0] rdata_reg, rdata_next;

    // Address decode; the only access path is this controller port
    wire aligned = (req.addr[1:0] == 2'b00);
    wire in_groups = aligned && (req.addr < GROUP_END);
    wire [9:0] grp_num = req.addr / EIA_GROUP_STRIDE;
    wire [9:0] sub_ofs = req.addr % EIA_GROUP_STRIDE;
    wire blk_set_hit = req.wr && (req.addr == EIA_OFS_BLK_SET);
    wire blk_clr_hit = req.wr && (req.addr == EIA_OFS_BLK_CLR);
    // Exact match on either port, so alignment is implied
    wire blk_addr = (req.addr == EIA_OFS_BLK_SET) || (req.addr == EIA_OFS_BLK_CLR);
    wire [NUM_GROUPS-1:0] blk_wbits = req.wdata[EIA_FIRST_IRQ +: NUM_GROUPS];

    // Exceptions are wired through, so nothing here can hold them off
    assign exc_out = exc_in;

    // Per-group storage and next-state logic
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
        wire sel = in_groups && (grp_num == 10'(g));
        wire [31:0] src_clr = (req.wr && sel && sub_ofs == EIA_OFS_SRC) ? req.wdata : 32'h0;
        wire [31:0] en_set = (req.wr && sel && sub_ofs == EIA_OFS_EN_SET) ? req.wdata : 32'h0;
        wire [31:0] en_clr = (req.wr && sel && sub_ofs == EIA_OFS_EN_CLR) ? req.wdata : 32'h0;
        // A result-offset write decodes to none of the strobes above
        // Arriving event beats a write-one clear in the same cycle
        assign src_next[g] = (src_reg[g] & ~src_clr) | irq_src[g];
        assign en_next[g] = (en_reg[g] | en_set) & ~en_clr;
        assign result[g] = src_reg[g] & en_reg[g];
        assign group_irq_next[g] = (|result[g]) & blk_reg[g];
        assign direct_irq_next[g] = result[g] & {32{direct_vector_enable}};
        // Clockless path so a stopped clock still lets sources wake the chip
        assign wake_hit[g] = irq_src[g] & en_reg[g] & wake_capable[g];
    end

    assign blk_next = (blk_reg | (blk_set_hit ? blk_wbits : '0))
                      & ~(blk_clr_hit ? blk_wbits : '0);

    // Read mux; unmapped and reserved words read zero
    always_comb begin
        rdata_next = rdata_reg;
        if (req.rd) begin
            rdata_next = EIA_RD_RST;
            if (in_groups) begin
                for (int g = 0; g < NUM_GROUPS; g++) begin
                    if (grp_num == 10'(g)) begin
                        case (sub_ofs)
                            EIA_OFS_SRC: rdata_next = src_reg[g];
                            EIA_OFS_EN_SET: rdata_next = en_reg[g];
                            EIA_OFS_EN_CLR: rdata_next = en_reg[g];
                            EIA_OFS_RESULT: rdata_next = result[g];
                            default: rdata_next = EIA_RD_RST;
                        endcase
                    end
                end
            end else if (blk_addr) begin
                rdata_next = 32'(blk_reg) << EIA_FIRST_IRQ;
            end
        end
    end

    // All state on the standby rail; nothing needs a mode setting
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            src_reg <= {NUM_GROUPS{EIA_SRC_RST}};
            en_reg <= {NUM_GROUPS{EIA_EN_RST}};
            blk_reg <= '0;
        end else begin
            src_reg <= src_next;
            en_reg <= en_next;
            blk_reg <= blk_next;
        end
    end

    // Registered outputs towards the interrupt controller
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            group_irq_reg <= '0;
            direct_irq_reg <= '0;
            rdata_reg <= EIA_RD_RST;
        end else begin
            group_irq_reg <= group_irq_next;
            direct_irq_reg <= direct_irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign group_irq = group_irq_reg;
    assign direct_irq = direct_irq_reg;
    assign rdata = rdata_reg;
    // Combinational on purpose: a registered wake would need the clock it wakes
    assign wake_event = |wake_hit;

    // Checks on group 0 stand for all groups, since every group is one generate copy
    wire g0_src_wr = req.wr && in_groups && grp_num == 10'd0 && sub_ofs == EIA_OFS_SRC;
    wire g0_set_wr = req.wr && in_groups && grp_num == 10'd0 && sub_ofs == EIA_OFS_EN_SET;
    wire g0_clr_wr = req.wr && in_groups && grp_num == 10'd0 && sub_ofs == EIA_OFS_EN_CLR;
    wire g0_res_wr = req.wr && in_groups && grp_num == 10'd0 && sub_ofs == EIA_OFS_RESULT;
    wire g0_en_rd = req.rd && in_groups && grp_num == 10'd0
                    && (sub_ofs == EIA_OFS_EN_SET || sub_ofs == EIA_OFS_EN_CLR);

    property p_src_latch;
        @(posedge clk) disable iff (!nrst)
        (irq_src[0] != 32'h0) |=> ((src_reg[0] & $past(irq_src[0])) == $past(irq_src[0]));
    endproperty
    a_src_latch: assert property (p_src_latch) else $error("source event not latched");

    property p_src_hold;
        @(posedge clk) disable iff (!nrst)
        (!g0_src_wr && irq_src[0] == 32'h0) |=> $stable(src_reg[0]);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("source changed without cause");

    property p_src_clear;
        @(posedge clk) disable iff (!nrst)
        g0_src_wr |=>
            (src_reg[0] == (($past(src_reg[0]) & ~$past(req.wdata)) | $past(irq_src[0])));
    endproperty
    a_src_clear: assert property (p_src_clear) else $error("source clear wrong");

    property p_en_set;
        @(posedge clk) disable iff (!nrst)
        g0_set_wr |=> (en_reg[0] == ($past(en_reg[0]) | $past(req.wdata)));
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable set wrong");

    property p_en_clr;
        @(posedge clk) disable iff (!nrst)
        g0_clr_wr |=> (en_reg[0] == ($past(en_reg[0]) & ~$past(req.wdata)));
    endproperty
    a_en_clr: assert property (p_en_clr) else $error("enable clear wrong");

    property p_en_read;
        @(posedge clk) disable iff (!nrst)
        g0_en_rd |=> (rdata == $past(en_reg[0]));
    endproperty
    a_en_read: assert property (p_en_read) else $error("enable readback differs");

    property p_result_ro;
        @(posedge clk) disable iff (!nrst)
        (g0_res_wr && irq_src[0] == 32'h0) |=> ($stable(src_reg[0]) && $stable(en_reg[0]));
    endproperty
    a_result_ro: assert property (p_result_ro) else $error("result write had effect");

    property p_group_irq;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> (group_irq[0] == ($past(|(src_reg[0] & en_reg[0])) && $past(blk_reg[0])));
    endproperty
    a_group_irq: assert property (p_group_irq) else $error("group interrupt wrong");

    property p_direct;
        @(posedge clk) disable iff (!nrst)
        !direct_vector_enable |=> (direct_irq[0] == 32'h0);
    endproperty
    a_direct: assert property (p_direct) else $error("direct vector without enable");

    property p_blk_set;
        @(posedge clk) disable iff (!nrst)
        (blk_set_hit && req.wdata[EIA_FIRST_IRQ]) |=> blk_reg[0];
    endproperty
    a_blk_set: assert property (p_blk_set) else $error("block select not set");

    property p_wake;
        @(posedge clk) disable iff (!nrst)
        ((irq_src[0] & en_reg[0] & wake_capable[0]) != 32'h0) |-> wake_event;
    endproperty
    a_wake: assert property (p_wake) else $error("wake event missing");

    property p_exc;
        @(posedge clk) disable iff (!nrst)
        exc_in.reset |-> exc_out.reset;
    endproperty
    a_exc: assert property (p_exc) else $error("exception masked");

    // Main scenarios
    property p_cov_group;
        @(posedge clk) disable iff (!nrst)
        $rose(group_irq[0]);
    endproperty
    c_cov_group: cover property (p_cov_group);

    property p_cov_direct;
        @(posedge clk) disable iff (!nrst)
        direct_irq[0] != 32'h0;
    endproperty
    c_cov_direct: cover property (p_cov_direct);

    property p_cov_clear;
        @(posedge clk) disable iff (!nrst)
        g0_src_wr && src_reg[0] != 32'h0 ##1 src_reg[0] == 32'h0;
    endproperty
    c_cov_clear: cover property (p_cov_clear);

    property p_cov_wake;
        @(posedge clk) disable iff (!nrst)
        $rose(wake_event);
    endproperty
    c_cov_wake: cover property (p_cov_wake);
endmodule // eia_aggregator

// ===== dv/eia_vic_model.sv
`timescale 1ns/1ns
module eia_vic_model
    import eia_pkg::*;
#(
    parameter int NUM_GROUPS = EIA_NUM_GROUPS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Lines from the aggregator
    input wire logic [NUM_GROUPS-1:0] group_irq,
    input wire logic [NUM_GROUPS-1:0][31:0] direct_irq,
    // Pending state as the core would see it
    output logic [NUM_GROUPS-1:0] grp_pend,
    output logic dir_pend
);
    // Sticky pending; never serviced, so any stray pulse stays visible
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            grp_pend <= '0;
            dir_pend <= 1'b0;
        end else begin
            grp_pend <= grp_pend | group_irq;
            dir_pend <= dir_pend | (|direct_irq);
        end
    end
endmodule // eia_vic_model

// ===== dv/test_ec_interrupt_aggregator.sv
`timescale 1ns/1ns
module test_ec_interrupt_aggregator
    import eia_pkg::*;
;
    localparam int G = EIA_NUM_GROUPS;
    logic clk, nrst, dve, wake_event, dir_pend;
    eia_req_s req;
    logic [31:0] rdata;
    logic [G-1:0][31:0] irq_src, wake_cap, direct_irq;
    logic [G-1:0] group_irq, grp_pend;
    eia_exc_s exc_in, exc_out;
    int n_errors = 0;
    int num_checks = 0;

    eia_aggregator #(.NUM_GROUPS(G)) u_eia_aggregator (.clk(clk), .nrst(nrst), .req(req),
        .rdata(rdata), .irq_src(irq_src), .wake_capable(wake_cap),
        .direct_vector_enable(dve), .group_irq(group_irq), .direct_irq(direct_irq),
        .wake_event(wake_event), .exc_in(exc_in), .exc_out(exc_out));
    eia_vic_model #(.NUM_GROUPS(G)) u_eia_vic_model (.clk(clk), .nrst(nrst),
        .group_irq(group_irq), .direct_irq(direct_irq), .grp_pend(grp_pend),
        .dir_pend(dir_pend));

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compare, count, report
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle strobes; a gap cycle follows so strobes never merge
    task automatic wr(logic [9:0] a, logic [31:0] d);
        @(posedge clk);
        req <= {1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(logic [9:0] a, logic [31:0] exp, string name);
        @(posedge clk);
        req <= {1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clk);
        req <= '0;
        #1;
        chk(name, rdata, exp);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog, far beyond the roughly 80 cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    // Test sequence
    initial begin
        nrst = 1'b0;
        req = '0;
        irq_src = '0;
        wake_cap = '0;
        dve = 1'b0;
        exc_in = 3'b101;
        #1;
        chk("exc in reset", 32'(exc_out), 32'h5);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(10'h000, 32'h0, "src0 rst");
        rd(10'h00c, 32'h0, "en0 rst");
        rd(10'h200, 32'h0, "blk rst");
        $display("test reset done");
        wr(10'h004, 32'h0000_00a5);
        wr(10'h004, 32'h0000_0000);
        rd(10'h004, 32'h0000_00a5, "en set rd");
        wr(10'h00c, 32'h0000_0021);
        rd(10'h00c, 32'h0000_0084, "en clr rd");
        rd(10'h004, 32'h0000_0084, "en set rd2");
        rd(10'h010, 32'h0, "reserved");
        rd(10'h3fc, 32'h0, "unmapped");
        $display("test enable done");
        // Group 0 carries the design's own checks, so exercise it first
        @(posedge clk);
        irq_src[0] <= 32'h0000_0004;
        wake_cap[0] <= 32'h0000_0004;
        #2;
        chk("wake0", 32'(wake_event), 32'h1);
        @(posedge clk);
        irq_src[0] <= '0;
        wake_cap[0] <= '0;
        rd(10'h008, 32'h0000_0004, "result0");
        wr(10'h008, 32'hffff_ffff);
        wr(10'h200, 32'h0000_0100);
        tick(2);
        chk("grp0 on", 32'(group_irq), 32'h1);
        wr(10'h000, 32'h0000_0004);
        rd(10'h000, 32'h0, "src0 w1c");
        chk("grp0 off", 32'(group_irq), 32'h0);
        wr(10'h204, 32'h0000_0100);
        $display("test group0 done");
        wr(10'h018, 32'h0000_0008);
        @(posedge clk);
        irq_src[1] <= 32'h0000_0028;
        @(posedge clk);
        irq_src[1] <= '0;
        rd(10'h014, 32'h0000_0028, "src1 held");
        rd(10'h01c, 32'h0000_0008, "result1");
        wr(10'h01c, 32'hffff_ffff);
        rd(10'h01c, 32'h0000_0008, "result ro");
        chk("grp blocked", 32'(group_irq), 32'h0);
        wr(10'h200, 32'h0000_0200);
        tick(2);
        chk("grp1 on", 32'(group_irq), 32'h2);
        rd(10'h204, 32'h0000_0200, "blk rd");
        chk("vic grp", 32'(grp_pend), 32'h3);
        wr(10'h204, 32'h0000_0200);
        tick(2);
        chk("grp1 off", 32'(group_irq), 32'h0);
        $display("test group done");
        // Group line is off before direct vectors go on
        @(posedge clk);
        dve <= 1'b1;
        tick(2);
        chk("direct1", direct_irq[1], 32'h0000_0008);
        chk("vic dir", 32'(dir_pend), 32'h1);
        wr(10'h014, 32'h0000_0008);
        rd(10'h014, 32'h0000_0020, "src w1c");
        chk("direct1 off", direct_irq[1], 32'h0);
        $display("test direct done");
        wr(10'h004, 32'h0000_0001);
        @(posedge clk);
        irq_src[0][0] <= 1'b1;
        #2;
        chk("wake not capable", 32'(wake_event), 32'h0);
        @(posedge clk);
        wake_cap[0][0] <= 1'b1;
        #2;
        chk("wake", 32'(wake_event), 32'h1);
        @(posedge clk);
        irq_src[0][0] <= 1'b0;
        #2;
        chk("wake gone", 32'(wake_event), 32'h0);
        chk("direct0", direct_irq[0], 32'h0000_0001);
        $display("test wake done");
        @(posedge clk);
        exc_in <= 3'b010;
        nrst <= 1'b0;
        #1;
        chk("exc pass", 32'(exc_out), 32'h2);
        chk("direct rst", direct_irq[0], 32'h0);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(10'h004, 32'h0, "en0 rst");
        rd(10'h014, 32'h0, "src1 rst");
        $display("test reset again done");
        end_of_test();
    end
endmodule // test_ec_interrupt_aggregator
